// [include/abf_pkg.sv]
// constants and types for the asynchronous byte fifo port
// Notes on behaviour
// - The data bus is an input except while the read strobe is low during a read of a waiting byte in fifo mode.
// - The receive flag is low when a byte waits and the receive state is ABF_RX_IDLE, high otherwise.
// - After each read strobe rise the receive flag stays high for one cycle (ABF_RX_HOLD); it is already high from the read fall.
// - The transmit flag is low when a byte can be taken, else high.
// - In reset both flags are undriven so the pull-up holds them high.
// - A read strobe fall puts the head receive byte on the bus.
// - A read strobe rise advances the receive buffer.
// - A write strobe fall captures the bus byte into transmit storage.
// - In suspend with wakeup enabled a flush pulse requests resume.
// - In normal power a flush pulse sends all pending transmit data.
// - The port works only when configuration selects fifo mode.
package abf_pkg;
  localparam int ABF_DATA_W = 8;
  localparam int ABF_DEPTH = 4;
  localparam logic ABF_FLAG_IDLE = 1'b1;
  localparam logic [7:0] ABF_DATA_RST = 8'h00;
  // receive side state, one-hot
  typedef enum logic [2:0] {
    ABF_RX_IDLE = 3'b001,
    ABF_RX_DRIVE = 3'b010,
    ABF_RX_HOLD = 3'b100
  } abf_rx_state_t;
endpackage

// [hdl/abf_sync_edge.sv]
// two-flop synchroniser with fall and rise detection
`timescale 1ns/1ns
module abf_sync_edge (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // async level in
  input wire logic async_in,
  // synchronised level and edges
  output logic level_out,
  output logic fall_out,
  output logic rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // only sync_reg reads meta_reg; idle high matches the pulled strobes
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges seen once per transition
  assign level_out = sync_reg;
  assign fall_out = last_reg & ~sync_reg;
  assign rise_out = ~last_reg & sync_reg;
endmodule

// [hdl/abf_fifo_port.sv]
// asynchronous byte fifo port for one channel
`timescale 1ns/1ns
module abf_fifo_port
  import abf_pkg::*;
#(
  parameter int DEPTH = ABF_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // configuration and power state
  input wire logic fifo_mode_in,
  input wire logic wake_enable_in,
  input wire logic powered_config_n_in,
  // external strobes
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic flush_wake_n_in,
  // data bus pins
  input wire logic [7:0] chan_data_in,
  output logic [7:0] chan_data_out,
  output logic chan_data_oe_out,
  // flag pins
  output logic rx_avail_n_out,
  output logic rx_avail_n_oe_out,
  output logic tx_space_n_out,
  output logic tx_space_n_oe_out,
  // usb side receive feed
  input wire logic usb_rx_valid_in,
  input wire logic [7:0] usb_rx_data_in,
  output logic usb_rx_ready_out,
  // usb side transmit drain
  output logic usb_tx_valid_out,
  output logic [7:0] usb_tx_data_out,
  input wire logic usb_tx_ready_in,
  // usb engine requests
  output logic send_now_out,
  output logic resume_req_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic rd_lvl, rd_fall, rd_rise;
  logic wr_fall;
  logic fw_fall;

  abf_sync_edge u_rd (.clk_in(clk_in), .resetn_in(resetn_in),
    .async_in(rd_n_in), .level_out(rd_lvl), .fall_out(rd_fall),
    .rise_out(rd_rise));
  abf_sync_edge u_wr (.clk_in(clk_in), .resetn_in(resetn_in),
    .async_in(wr_n_in), .level_out(), .fall_out(wr_fall),
    .rise_out());
  abf_sync_edge u_fw (.clk_in(clk_in), .resetn_in(resetn_in),
    .async_in(flush_wake_n_in), .level_out(), .fall_out(fw_fall),
    .rise_out());

  // receive storage
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_reg, rx_rp_reg;
  logic [AW:0] rx_cnt_reg;
  // transmit storage
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_reg, tx_rp_reg;
  logic [AW:0] tx_cnt_reg;

  abf_rx_state_t rx_st_reg, rx_st_next;
  logic [7:0] data_out_reg;
  logic live_reg;
  logic send_reg, resume_reg;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // port lives only in fifo mode; live_reg also ends reset
  wire active = live_reg & fifo_mode_in;
  wire rx_has = (rx_cnt_reg != '0);
  wire tx_full = (tx_cnt_reg == FULL_CNT);
  wire rx_push = usb_rx_valid_in & usb_rx_ready_out;
  // advance on read rise after a drive
  wire rx_pop = active & rd_rise & (rx_st_reg == ABF_RX_DRIVE);
  // capture on write fall while room
  wire tx_push = active & wr_fall & ~tx_full;
  wire tx_pop = usb_tx_valid_out & usb_tx_ready_in;

  assign usb_rx_ready_out = (rx_cnt_reg != FULL_CNT);
  assign usb_tx_valid_out = (tx_cnt_reg != '0);
  assign usb_tx_data_out = tx_mem[tx_rp_reg];

  // receive state: idle, drive on read low, hold one cycle after rise
  always_comb begin
    rx_st_next = rx_st_reg;
    case (rx_st_reg)
      ABF_RX_IDLE: begin
        if (active & rd_fall & rx_has)
          rx_st_next = ABF_RX_DRIVE;
      end
      ABF_RX_DRIVE: begin
        if (rd_rise)
          rx_st_next = ABF_RX_HOLD;
      end
      ABF_RX_HOLD: rx_st_next = ABF_RX_IDLE;
      default: rx_st_next = ABF_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_st_reg <= ABF_RX_IDLE;
      live_reg <= 1'b0;
    end else begin
      rx_st_reg <= rx_st_next;
      live_reg <= 1'b1;
    end
  end

  // receive pointers and count
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_reg] <= usb_rx_data_in;
        rx_wp_reg <= ptr_inc(rx_wp_reg);
      end
      if (rx_pop)
        rx_rp_reg <= ptr_inc(rx_rp_reg);
      rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // transmit pointers and count
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_reg] <= chan_data_in;
        tx_wp_reg <= ptr_inc(tx_wp_reg);
      end
      if (tx_pop)
        tx_rp_reg <= ptr_inc(tx_rp_reg);
      tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // latch head byte on read fall
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      data_out_reg <= ABF_DATA_RST;
    else if (active & rd_fall & rx_has)
      data_out_reg <= rx_mem[rx_rp_reg];
  end

  // flush or wake pulse, one cycle, decided by power state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      send_reg <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      send_reg <= active & fw_fall & ~powered_config_n_in;
      resume_reg <= active & fw_fall & powered_config_n_in & wake_enable_in;
    end
  end
  assign send_now_out = send_reg;
  assign resume_req_out = resume_reg;

  // drive only while read held low
  // the pin term drops the drive at once; the synced level lags two clocks
  assign chan_data_oe_out = (rx_st_reg == ABF_RX_DRIVE) & ~rd_lvl & ~rd_n_in;
  assign chan_data_out = data_out_reg;
  // flag high while reading and one cycle after rise
  assign rx_avail_n_out = ~(rx_has & (rx_st_reg == ABF_RX_IDLE));
  assign tx_space_n_out = tx_full;
  // flags undriven in reset and when the port is off
  assign rx_avail_n_oe_out = active;
  assign tx_space_n_oe_out = active;

  // bus driven only while read strobe low
  bus_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    chan_data_oe_out |-> !rd_lvl) else $error("bus driven, read high");
  // receive flag follows buffer
  rx_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (active && rx_st_reg == ABF_RX_IDLE) |-> (rx_avail_n_out == !rx_has))
    else $error("receive flag wrong");
  // flag high right after read rise
  rx_rise_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rx_pop |=> rx_avail_n_out) else $error("flag low after read rise");
  // transmit flag rises as the last slot fills
  tx_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (tx_push && !tx_pop && tx_cnt_reg == FULL_CNT - 1'b1) |=> tx_space_n_out)
    else $error("transmit flag wrong");
  // flags released while off
  flag_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !fifo_mode_in |-> !rx_avail_n_oe_out && !tx_space_n_oe_out)
    else $error("flag driven when off");
  // head byte lands on bus
  head_byte_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (active && rd_fall && rx_has) |=> data_out_reg == $past(rx_mem[rx_rp_reg]))
    else $error("wrong head byte");
  // read rise pops one
  rx_pop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rx_pop && !rx_push) |=> rx_cnt_reg == $past(rx_cnt_reg) - 1'b1)
    else $error("receive not advanced");
  // write fall stores one
  tx_push_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (tx_push && !tx_pop) |=> tx_cnt_reg == $past(tx_cnt_reg) + 1'b1)
    else $error("write not captured");
  // resume only in suspend
  resume_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (active && fw_fall && powered_config_n_in && wake_enable_in) |=>
    resume_req_out && !send_now_out) else $error("no resume");
  // flush only in normal power
  flush_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (active && fw_fall && !powered_config_n_in) |=> send_now_out)
    else $error("no flush");
  // no write capture and no read advance outside fifo mode
  mode_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !fifo_mode_in |-> !tx_push && !rx_pop) else $error("active off mode");
  // one edge acted on once
  edge_once_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_fall |=> !wr_fall) else $error("edge twice");
endmodule

// [tb/abf_host_model.sv]
// external controller model that drives the strobes and the data bus
`timescale 1ns/1ns
module abf_host_model (
  // clock
  input wire logic clk_in,
  // flag levels at the board pins
  input wire logic rx_pin_in,
  input wire logic tx_pin_in,
  // strobes and bus drive
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [7:0] bus_out,
  output logic bus_oe_out
);
  // idle strobes high, bus released
  initial begin
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    bus_out = 8'h00;
    bus_oe_out = 1'b0;
  end
  // read on flag
  // blind reads exist only to prove that an empty port stays off the bus
  task automatic rd(input bit blind);
    do @(negedge clk_in); while (!blind && rx_pin_in !== 1'b0);
    @(posedge clk_in);
    rd_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    rd_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
  // write on space
  // data is held well past the fall, since it is sampled late
  task automatic wr(input logic [7:0] b);
    do @(negedge clk_in); while (tx_pin_in !== 1'b0);
    @(posedge clk_in);
    bus_out <= b;
    bus_oe_out <= 1'b1;
    wr_n_out <= 1'b0;
    repeat (5) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus_oe_out <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
endmodule

// [tb/async_byte_fifo_port_tb.sv]
// self-checking bench for the asynchronous byte fifo port
`timescale 1ns/1ns
module async_byte_fifo_port_tb;
  import abf_pkg::*;
  logic clk_in, resetn_in, fifo_mode, wake_en, pwr_n, flush_n, oe_d;
  logic rxv, txr, d_oe, rx_n, rx_oe, tx_n, tx_oe, rxr, txv, snd, res;
  logic h_rd, h_wr, h_oe, rx_pin, tx_pin;
  logic [7:0] rxd, d_out, txd, h_bus, bus, b;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int errors = 0, n_checks = 0, n_snd = 0, n_res = 0, cyc = 0;
  int seed = 19, a, c;
  // pins: pull-ups on flags, released bus shows the inverse of last byte
  assign rx_pin = rx_oe ? rx_n : 1'b1;
  assign tx_pin = tx_oe ? tx_n : 1'b1;
  assign bus = d_oe ? d_out : (h_oe ? h_bus : ~h_bus);
  abf_fifo_port #(.DEPTH(4)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .fifo_mode_in(fifo_mode), .wake_enable_in(wake_en),
    .powered_config_n_in(pwr_n), .rd_n_in(h_rd), .wr_n_in(h_wr),
    .flush_wake_n_in(flush_n), .chan_data_in(bus), .chan_data_out(d_out),
    .chan_data_oe_out(d_oe), .rx_avail_n_out(rx_n),
    .rx_avail_n_oe_out(rx_oe), .tx_space_n_out(tx_n),
    .tx_space_n_oe_out(tx_oe), .usb_rx_valid_in(rxv),
    .usb_rx_data_in(rxd), .usb_rx_ready_out(rxr), .usb_tx_valid_out(txv),
    .usb_tx_data_out(txd), .usb_tx_ready_in(txr), .send_now_out(snd),
    .resume_req_out(res));
  abf_host_model i_host (.clk_in(clk_in), .rx_pin_in(rx_pin),
    .tx_pin_in(tx_pin), .rd_n_out(h_rd), .wr_n_out(h_wr), .bus_out(h_bus),
    .bus_oe_out(h_oe));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // usb side feed, noting each byte for the read watcher
  task automatic feed(input logic [7:0] v);
    @(posedge clk_in);
    rxv <= 1'b1;
    rxd <= v;
    rx_q.push_back(v);
    do @(negedge clk_in); while (rxr !== 1'b1);
    @(posedge clk_in);
    rxv <= 1'b0;
  endtask
  // clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // watcher on the falling edge, where outputs have settled
  always @(negedge clk_in) begin
    oe_d <= d_oe;
    if (d_oe === 1'b1)
      chk({7'h00, h_rd}, 8'h00);
    cyc <= cyc + 1;
    n_snd <= n_snd + int'(snd === 1'b1);
    n_res <= n_res + int'(res === 1'b1);
    if (d_oe === 1'b1 && oe_d !== 1'b1)
      chk(d_out, rx_q.size() ? rx_q.pop_front() : ~d_out);
    if (txv === 1'b1 && txr === 1'b1)
      chk(txd, tx_q.size() ? tx_q.pop_front() : ~txd);
    if (cyc > 20000) begin
      errors++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    {resetn_in, fifo_mode, wake_en, pwr_n, flush_n} = 5'b01001;
    {rxv, txr, rxd} = 10'h000;
    repeat (5) @(posedge clk_in);
    chk({4'h0, rx_oe, tx_oe, rx_pin, tx_pin}, 8'h03);
    resetn_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk({6'h00, rx_pin, tx_pin}, 8'h02);
    for (int i = 0; i < 4; i++) feed(8'($random(seed)));
    repeat (4) @(negedge clk_in);
    chk({7'h00, rx_pin}, 8'h00);
    for (int i = 0; i < 4; i++) i_host.rd(1'b0);
    @(negedge clk_in);
    chk({7'h00, rx_pin}, 8'h01);
    chk(8'(rx_q.size()), 8'h00);
    i_host.rd(1'b1);
    $display("read test done");
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      tx_q.push_back(b);
      i_host.wr(b);
    end
    repeat (2) @(negedge clk_in);
    chk({7'h00, tx_pin}, 8'h01);
    repeat (20) @(posedge clk_in) txr <= 1'($random(seed));
    txr <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk({7'h00, tx_pin}, 8'h00);
    chk(8'(tx_q.size()), 8'h00);
    $display("write test done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_in);
      {pwr_n, wake_en} <= {k != 0, k == 1};
      repeat (3) @(posedge clk_in);
      a = n_snd;
      c = n_res;
      flush_n <= 1'b0;
      repeat (5) @(posedge clk_in);
      flush_n <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk(8'(2 * (n_snd - a) + n_res - c), 8'(2 * (k == 0) + (k == 1)));
    end
    $display("flush test done");
    fifo_mode <= 1'b0;
    repeat (4) @(negedge clk_in);
    chk({4'h0, rx_oe, tx_oe, rx_pin, tx_pin}, 8'h03);
    @(posedge clk_in);
    fifo_mode <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk({7'h00, tx_pin}, 8'h00);
    $display("mode test done");
    tally_and_finish;
  end
endmodule
